// ===== ccp_channel.sv
// One compare/capture channel: match, capture edge and pin level.
// Assumes the pin input is synchronous and count_en is a one-cycle pulse.
`timescale 1ns/1ps
module ccp_channel (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Configuration
  input  wire logic [3:0]  ioctl,
  input  wire logic        pwm,
  input  wire logic        init_lvl,
  input  wire logic        init_ld,
  input  wire logic        period_hit,
  // Counter and register value
  input  wire logic        count_en,
  input  wire logic [15:0] count,
  input  wire logic [15:0] compare,
  // Pin
  input  wire logic        pin_in,
  output logic             pin_out_q,
  output logic             pin_oe_q,
  // Events
  output logic             match,
  output logic             capture
);
  logic pin_prev_q, pin_prev_d;
  logic pin_out_d;

  // Compare and capture detection
  always_comb begin
    match   = !ioctl[ccp_pkg::IOCTL_CAP] && count_en && (count == compare);
    capture = ioctl[ccp_pkg::IOCTL_CAP] &&
              ((ioctl[0] && pin_in && !pin_prev_q) || (ioctl[1] && !pin_in && pin_prev_q));
    pin_prev_d = pin_in;
    pin_out_d  = pin_out_q;
    if (init_ld)
      pin_out_d = init_lvl;
    else if (pwm) begin
      // High at period start, low at duty match
      if (match)
        pin_out_d = 1'b0;
      else if (period_hit)
        pin_out_d = 1'b1;
    end else if (match) begin
      unique case (ioctl[1:0])
        2'h0: pin_out_d = pin_out_q;
        2'h1: pin_out_d = 1'b0;
        2'h2: pin_out_d = 1'b1;
        2'h3: pin_out_d = !pin_out_q;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_prev_q <= 1'b0;
      pin_out_q  <= 1'b0;
      pin_oe_q   <= 1'b0;
    end else begin
      pin_prev_q <= pin_prev_d;
      pin_out_q  <= pin_out_d;
      pin_oe_q   <= !ioctl[ccp_pkg::IOCTL_CAP];
    end
  end
endmodule // ccp_channel

// ===== ccp_pins_model.sv
// Model of the far side of the timer pins: channel wires and event input.
// Assumes one system clock; bit 0 of each vector is channel A.
`timescale 1ns/1ps
module ccp_pins_model (
  // Clock
  input  wire logic       clk_sys,
  // Design side of the channel pins
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  // Resolved wire levels and event input
  output logic [3:0]      pin_lvl,
  output logic            ext_clk
);
  logic [3:0] drv_q = 4'h0;
  initial ext_clk = 1'b0;

  // Design wins where it drives, far side elsewhere
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & drv_q);

  // Far side levels change one edge after the request
  task automatic set_pins(input logic [3:0] v);
    @(posedge clk_sys);
    drv_q <= v;
  endtask

  // Event pulses, w cycles high then w low; w of 1 is the fast case
  task automatic ext_pulses(input int n, input int w);
    repeat (n) begin
      @(posedge clk_sys);
      ext_clk <= 1'b1;
      repeat (w) @(posedge clk_sys);
      ext_clk <= 1'b0;
      repeat (w - 1) @(posedge clk_sys);
    end
  endtask
endmodule // ccp_pins_model

// ===== ccp_pkg.sv
// Package of constants for the 16-bit capture/compare timer.
// Assumes a single 250 MHz clock and an APB register slave.
package ccp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_IOCTL  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK   = 8'h10;
  localparam logic [7:0] OFF_COUNT  = 8'h14;
  localparam logic [7:0] OFF_GRA    = 8'h18;
  localparam logic [7:0] OFF_GRB    = 8'h1C;
  localparam logic [7:0] OFF_GRC    = 8'h20;
  localparam logic [7:0] OFF_GRD    = 8'h24;
  localparam logic [7:0] OFF_STBY   = 8'h28;
  // Mode register fields
  localparam int MODE_START  = 7;
  localparam int MODE_BUFB   = 5;
  localparam int MODE_BUFA   = 4;
  localparam int MODE_PWM_LO = 0;
  // Control register fields
  localparam int CTRL_CLR    = 7;
  localparam int CTRL_CKS_LO = 4;
  localparam int CTRL_INIT_LO = 0;
  // I/O control: 4 bits per channel, bit 3 = capture, bits 1:0 = action/edge
  localparam int IOCTL_W     = 4;
  localparam int IOCTL_CAP   = 3;
  // Status/mask bit positions (0..3 channels)
  localparam int STAT_OVF    = 4;
  // Reset values
  localparam logic [7:0]  MODE_RST  = 8'h48;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] GR_RST    = 16'hFFFF;
  localparam logic        STBY_RST  = 1'b1;
  localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
  // Clock select codes
  localparam logic [2:0] CKS_EXT = 3'h7;
  // Subclock prescale: 250 MHz / 32.768 kHz is about 7629 cycles
  localparam int SUB_HZ   = 32768;
  localparam int SYS_HZ   = 250000000;
  localparam int SUB_DIV  = SYS_HZ / SUB_HZ;
endpackage

// ===== ccp_prescaler.sv
// Prescaler making one-cycle enables for the counter clock sources.
// Assumes one system clock; the subclock rate is a parameter of the top.
`timescale 1ns/1ps
module ccp_prescaler #(
  parameter int SUB_DIV = ccp_pkg::SUB_DIV
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Selection and enables
  input  wire logic [2:0] sel,
  input  wire logic       ext_rise,
  output logic            tick_q
);
  logic [2:0]  sys_q, sys_d;
  logic [15:0] sub_q, sub_d;
  logic [3:0]  subp_q, subp_d;
  logic        sub_tick;
  logic        tick_d;

  // Divider chains and source mux; the subclock is only a derived enable
  always_comb begin
    sys_d  = sys_q + 3'h1;
    sub_tick = (sub_q == 16'(SUB_DIV - 1));
    sub_d  = sub_tick ? 16'h0000 : sub_q + 16'h0001;
    subp_d = sub_tick ? subp_q + 4'h1 : subp_q;
    unique case (sel)
      3'h0: tick_d = 1'b1;
      3'h1: tick_d = sys_q[0];
      3'h2: tick_d = &sys_q[1:0];
      3'h3: tick_d = &sys_q;
      3'h4: tick_d = sub_tick;
      3'h5: tick_d = sub_tick && (&subp_q[1:0]);
      3'h6: tick_d = sub_tick && (&subp_q);
      ccp_pkg::CKS_EXT: tick_d = ext_rise;
    endcase
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sys_q  <= 3'h0;
      sub_q  <= 16'h0000;
      subp_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      sys_q  <= sys_d;
      sub_q  <= sub_d;
      subp_q <= subp_d;
      tick_q <= tick_d;
    end
  end
endmodule // ccp_prescaler

// ===== ccp_timer.sv
// Top of the 16-bit capture/compare timer with APB register slave.
// Assumes synchronous pins and one 250 MHz clock, synchronous reset.
// Overview of operation
// - One 16-bit up-counter is the time base for all four channels.
// - The count enable is chosen among seven internal rates and an external event.
// - Each general register is set to compare or capture on its own.
// - In buffer mode C buffers A and D buffers B.
// - A compare match drives the channel pin low, high or toggles it.
// - Capture latches the count on rising, falling or both pin edges.
// - With clearing enabled the counter returns to zero on a match with A.
// - PWM drives the B, C and D pins with period set by register A.
// - Software presets the initial level of each channel pin.
// - Four channel interrupts and one overflow interrupt exist.
// - After reset the timer sits in standby until released.
// - A dedicated input carries the external event clock.
// - A channel pin is an output in compare mode and an input in capture mode.
// - Clock-select code 111 counts rising edges of the external event pin.
// - The start bit halts counting at 0, allows it at 1, and resets to 0.
// - With the clear bit at 0 the counter runs freely.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module ccp_timer #(
  parameter int SUB_DIV = ccp_pkg::SUB_DIV
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata_q,
  output logic             pready_q,
  output logic             pslverr_q,
  // External event clock
  input  wire logic        ext_event_clock_in,
  // Channel pins
  input  wire logic        chan_a_pin_in,
  output logic             chan_a_pin_out,
  output logic             chan_a_pin_oe,
  input  wire logic        chan_b_pin_in,
  output logic             chan_b_pin_out,
  output logic             chan_b_pin_oe,
  input  wire logic        chan_c_pin_in,
  output logic             chan_c_pin_out,
  output logic             chan_c_pin_oe,
  input  wire logic        chan_d_pin_in,
  output logic             chan_d_pin_out,
  output logic             chan_d_pin_oe,
  // Interrupt
  output logic             irq_q
);
  logic [7:0]  mode_q, mode_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [15:0] ioctl_q, ioctl_d;
  logic [4:0]  status_q, status_d;
  logic [4:0]  mask_q, mask_d;
  logic [15:0] timer_count_q, timer_count_d;
  logic [15:0] general_reg_a_q, general_reg_a_d;
  logic [15:0] general_reg_b_q, general_reg_b_d;
  logic [15:0] general_reg_c_q, general_reg_c_d;
  logic [15:0] general_reg_d_q, general_reg_d_d;
  logic        stby_q, stby_d;
  logic        ext_prev_q;
  logic [31:0] prdata_d;
  logic        pready_d, pslverr_d, irq_d;
  logic        tick, count_en, wr, rd, init_ld;
  logic [3:0]  pin_in, pin_out, pin_oe, match, capture;
  logic [2:0]  clock_select_field;
  logic        clear_on_match_a_bit, bufa, bufb;
  logic [15:0] cmp [4];

  assign clock_select_field   = ctrl_q[ccp_pkg::CTRL_CKS_LO +: 3];
  assign clear_on_match_a_bit = ctrl_q[ccp_pkg::CTRL_CLR];
  assign bufa = mode_q[ccp_pkg::MODE_BUFA];
  assign bufb = mode_q[ccp_pkg::MODE_BUFB];
  assign pin_in = {chan_d_pin_in, chan_c_pin_in, chan_b_pin_in, chan_a_pin_in};
  assign wr = psel && penable && pwrite && !pready_q;
  assign rd = psel && penable && !pwrite && !pready_q;
  // Initial levels load on any control write, whether or not the counter runs
  assign init_ld = wr && (paddr == ccp_pkg::OFF_CTRL);
  // Standby or stopped counter blocks counting
  assign count_en = tick && !stby_q && mode_q[ccp_pkg::MODE_START];

  // Rate selection, external edge from the synchronous pin
  ccp_prescaler #(.SUB_DIV(SUB_DIV)) u_presc (
    .clk_sys (clk_sys),
    .srst    (srst),
    .sel     (clock_select_field),
    .ext_rise(ext_event_clock_in && !ext_prev_q),
    .tick_q  (tick)
  );

  assign cmp[0] = general_reg_a_q;
  assign cmp[1] = general_reg_b_q;
  assign cmp[2] = general_reg_c_q;
  assign cmp[3] = general_reg_d_q;

  // Four channels; A never runs PWM
  for (genvar i = 0; i < 4; i++) begin : g_chan
    ccp_channel u_chan (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .ioctl     (ioctl_q[i*ccp_pkg::IOCTL_W +: ccp_pkg::IOCTL_W]),
      .pwm       ((i == 0) ? 1'b0 : mode_q[ccp_pkg::MODE_PWM_LO + ((i == 0) ? 0 : i - 1)]),
      .init_lvl  (pwdata[ccp_pkg::CTRL_INIT_LO + i]),
      .init_ld   (init_ld),
      .period_hit(match[0]),
      .count_en  (count_en),
      .count     (timer_count_q),
      .compare   (cmp[i]),
      .pin_in    (pin_in[i]),
      .pin_out_q (pin_out[i]),
      .pin_oe_q  (pin_oe[i]),
      .match     (match[i]),
      .capture   (capture[i])
    );
  end

  assign chan_a_pin_out = pin_out[0];
  assign chan_b_pin_out = pin_out[1];
  assign chan_c_pin_out = pin_out[2];
  assign chan_d_pin_out = pin_out[3];
  assign chan_a_pin_oe  = pin_oe[0];
  assign chan_b_pin_oe  = pin_oe[1];
  assign chan_c_pin_oe  = pin_oe[2];
  assign chan_d_pin_oe  = pin_oe[3];

  // Counter, capture, buffers, register writes and status
  always_comb begin
    mode_d   = mode_q;
    ctrl_d   = ctrl_q;
    ioctl_d  = ioctl_q;
    mask_d   = mask_q;
    stby_d   = stby_q;
    timer_count_d   = timer_count_q;
    general_reg_a_d = general_reg_a_q;
    general_reg_b_d = general_reg_b_q;
    general_reg_c_d = general_reg_c_q;
    general_reg_d_d = general_reg_d_q;
    status_d = status_q;
    if (count_en) begin
      if (clear_on_match_a_bit && match[0])
        timer_count_d = 16'h0000;
      else
        timer_count_d = timer_count_q + 16'h0001;
    end
    // Capture: buffered pairs shift the old value into C or D
    if (capture[0]) begin
      general_reg_a_d = timer_count_q;
      if (bufa)
        general_reg_c_d = general_reg_a_q;
    end
    if (capture[1]) begin
      general_reg_b_d = timer_count_q;
      if (bufb)
        general_reg_d_d = general_reg_b_q;
    end
    if (capture[2] && !bufa)
      general_reg_c_d = timer_count_q;
    if (capture[3] && !bufb)
      general_reg_d_d = timer_count_q;
    // Compare: buffer register reloads the compare register on match
    if (match[0] && bufa && !ioctl_q[ccp_pkg::IOCTL_CAP])
      general_reg_a_d = general_reg_c_q;
    if (match[1] && bufb && !ioctl_q[ccp_pkg::IOCTL_W + ccp_pkg::IOCTL_CAP])
      general_reg_b_d = general_reg_d_q;
    if (wr) begin
      unique case (paddr)
        ccp_pkg::OFF_MODE:   mode_d  = pwdata[7:0] | ccp_pkg::MODE_RST;
        ccp_pkg::OFF_CTRL:   ctrl_d  = pwdata[7:0];
        ccp_pkg::OFF_IOCTL:  ioctl_d = pwdata[15:0];
        ccp_pkg::OFF_STATUS: status_d = status_q & ~pwdata[4:0];
        ccp_pkg::OFF_MASK:   mask_d  = pwdata[4:0];
        ccp_pkg::OFF_COUNT:  timer_count_d   = pwdata[15:0];
        ccp_pkg::OFF_GRA:    general_reg_a_d = pwdata[15:0];
        ccp_pkg::OFF_GRB:    general_reg_b_d = pwdata[15:0];
        ccp_pkg::OFF_GRC:    general_reg_c_d = pwdata[15:0];
        ccp_pkg::OFF_GRD:    general_reg_d_d = pwdata[15:0];
        ccp_pkg::OFF_STBY:   stby_d  = pwdata[0];
        default: ;
      endcase
    end
    // Events set after the clear so a coincident event is kept
    status_d[3:0] = status_d[3:0] | match | capture;
    if (count_en && timer_count_q == 16'hFFFF && !(clear_on_match_a_bit && match[0]))
      status_d[ccp_pkg::STAT_OVF] = 1'b1;
  end

  // APB answer: one wait state, read data registered
  always_comb begin
    pready_d  = psel && penable && !pready_q;
    pslverr_d = 1'b0;
    prdata_d  = ccp_pkg::BAD_ADDR_DATA;
    if (rd) begin
      unique case (paddr)
        ccp_pkg::OFF_MODE:   prdata_d = {24'h0, mode_q};
        ccp_pkg::OFF_CTRL:   prdata_d = {24'h0, ctrl_q};
        ccp_pkg::OFF_IOCTL:  prdata_d = {16'h0, ioctl_q};
        ccp_pkg::OFF_STATUS: prdata_d = {27'h0, status_q};
        ccp_pkg::OFF_MASK:   prdata_d = {27'h0, mask_q};
        ccp_pkg::OFF_COUNT:  prdata_d = {16'h0, timer_count_q};
        ccp_pkg::OFF_GRA:    prdata_d = {16'h0, general_reg_a_q};
        ccp_pkg::OFF_GRB:    prdata_d = {16'h0, general_reg_b_q};
        ccp_pkg::OFF_GRC:    prdata_d = {16'h0, general_reg_c_q};
        ccp_pkg::OFF_GRD:    prdata_d = {16'h0, general_reg_d_q};
        ccp_pkg::OFF_STBY:   prdata_d = {31'h0, stby_q};
        default:             pslverr_d = 1'b1;
      endcase
    end else if (wr && paddr > ccp_pkg::OFF_STBY)
      pslverr_d = 1'b1;
    irq_d = |(status_q & mask_q);
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_q          <= ccp_pkg::MODE_RST;
      ctrl_q          <= ccp_pkg::CTRL_RST;
      ioctl_q         <= 16'h0000;
      status_q        <= 5'h00;
      mask_q          <= 5'h00;
      timer_count_q   <= 16'h0000;
      general_reg_a_q <= ccp_pkg::GR_RST;
      general_reg_b_q <= ccp_pkg::GR_RST;
      general_reg_c_q <= ccp_pkg::GR_RST;
      general_reg_d_q <= ccp_pkg::GR_RST;
      stby_q          <= ccp_pkg::STBY_RST;
      ext_prev_q      <= 1'b0;
      prdata_q        <= 32'h0000_0000;
      pready_q        <= 1'b0;
      pslverr_q       <= 1'b0;
      irq_q           <= 1'b0;
    end else begin
      mode_q          <= mode_d;
      ctrl_q          <= ctrl_d;
      ioctl_q         <= ioctl_d;
      status_q        <= status_d;
      mask_q          <= mask_d;
      timer_count_q   <= timer_count_d;
      general_reg_a_q <= general_reg_a_d;
      general_reg_b_q <= general_reg_b_d;
      general_reg_c_q <= general_reg_c_d;
      general_reg_d_q <= general_reg_d_d;
      stby_q          <= stby_d;
      ext_prev_q      <= ext_event_clock_in;
      prdata_q        <= prdata_d;
      pready_q        <= pready_d;
      pslverr_q       <= pslverr_d;
      irq_q           <= irq_d;
    end
  end
endmodule // ccp_timer

// ===== ccp_timer_sva.sv
// Checker of the register bus and pin direction of the timer.
// Assumes it is bound to every timer instance; sees top ports only.
`timescale 1ns/1ps
module ccp_timer_sva (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata_q,
  input wire logic        pready_q,
  input wire logic        pslverr_q,
  // Pins and interrupt
  input wire logic        chan_b_pin_oe,
  input wire logic        irq_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic acc;
  logic wr;

  // Access phase and write request
  assign acc = psel && penable;
  assign wr  = psel && pwrite;

  chk_ready_wait: assert property (acc && !pready_q |=> pready_q) else $error("pready late");
  chk_ready_pulse: assert property (pready_q |=> !pready_q) else $error("pready held");
  chk_ready_cause: assert property (pready_q |-> $past(acc)) else $error("pready unasked");
  chk_err_unmapped: assert property (pready_q && paddr > ccp_pkg::OFF_STBY |-> pslverr_q)
    else $error("no error on unmapped");
  chk_err_mapped: assert property (pready_q && paddr <= ccp_pkg::OFF_STBY && paddr[1:0] == 2'h0
    |-> !pslverr_q) else $error("error on mapped");
  chk_rd_zero: assert property (pready_q && !pwrite && paddr > ccp_pkg::OFF_STBY
    |-> prdata_q == 32'h0) else $error("unmapped read data");
  chk_mode_fixed: assert property (pready_q && !pwrite && paddr == ccp_pkg::OFF_MODE
    |-> prdata_q[31:8] == 24'h0 && prdata_q[6] && prdata_q[3]) else $error("mode fixed bits");
  chk_oe_cause: assert property ($changed(chan_b_pin_oe)
    |-> $past(wr, 1) || $past(wr, 2) || $past(wr, 3) || $past(srst, 1) || $past(srst, 2))
    else $error("pin direction moved alone");

  // Main scenarios reached
  cover property (pready_q && pwrite);
  cover property (pready_q && pslverr_q);
  cover property ($rose(irq_q));
  cover property ($fell(chan_b_pin_oe));
endmodule // ccp_timer_sva

bind ccp_timer ccp_timer_sva ccp_timer_sva_i (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr,
  .prdata_q, .pready_q, .pslverr_q, .chan_b_pin_oe, .irq_q);

// ===== sixteen_bit_capture_compare_timer_bench.sv
// Self-checking bench of the capture/compare timer over APB.
// Assumes the pin model and checker files are compiled first.
`timescale 1ns/1ps
module sixteen_bit_capture_compare_timer_bench;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q, rd_q;
  logic        pready_q, pslverr_q, irq_q, err_q, ext_q;
  logic [3:0]  pout, poe, lvl;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;

  // Short subclock divide keeps the slow rates cheap
  ccp_timer #(.SUB_DIV(4)) ccp_timer_i (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_q, .pready_q, .pslverr_q, .ext_event_clock_in(ext_q),
    .chan_a_pin_in(lvl[0]), .chan_a_pin_out(pout[0]), .chan_a_pin_oe(poe[0]),
    .chan_b_pin_in(lvl[1]), .chan_b_pin_out(pout[1]), .chan_b_pin_oe(poe[1]),
    .chan_c_pin_in(lvl[2]), .chan_c_pin_out(pout[2]), .chan_c_pin_oe(poe[2]),
    .chan_d_pin_in(lvl[3]), .chan_d_pin_out(pout[3]), .chan_d_pin_oe(poe[3]), .irq_q);
  ccp_pins_model ccp_pins_model_i (.clk_sys, .pin_out(pout), .pin_oe(poe), .pin_lvl(lvl), .ext_clk(ext_q));

  // Clock and hang guard
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, s, e);
    end
  endtask

  // One APB transfer, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready_q !== 1'b1);
    rd_q = prdata_q;
    err_q = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask

  // Start with mode m, run n cycles, stop
  task automatic run(input logic [31:0] m, input int n);
    xfer(1'b1, ccp_pkg::OFF_MODE, m);
    repeat (n) @(posedge clk_sys);
    xfer(1'b1, ccp_pkg::OFF_MODE, 32'h0);
  endtask

  task automatic t_reset();
    rdc(ccp_pkg::OFF_MODE, {24'h0, ccp_pkg::MODE_RST});
    rdc(ccp_pkg::OFF_CTRL, 32'h0);
    rdc(ccp_pkg::OFF_STBY, 32'h1);
    rdc(ccp_pkg::OFF_GRA, 32'h0000FFFF);
    rdc(8'h40, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    run(32'h80, 20);
    rdc(ccp_pkg::OFF_COUNT, 32'h0);
    xfer(1'b1, ccp_pkg::OFF_STBY, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_compare();
    xfer(1'b1, ccp_pkg::OFF_IOCTL, 32'h0321);
    xfer(1'b1, ccp_pkg::OFF_CTRL, 32'h09);
    chk({28'h0, lvl}, 32'h9);
    for (int i = 0; i < 4; i++) xfer(1'b1, 8'(ccp_pkg::OFF_GRA + 4 * i), 32'(16 + i));
    xfer(1'b1, ccp_pkg::OFF_COUNT, 32'h0);
    xfer(1'b1, ccp_pkg::OFF_STATUS, 32'h1F);
    run(32'h80, 40);
    chk({28'h0, lvl}, 32'hE);
    rdc(ccp_pkg::OFF_STATUS, 32'h0F);
    xfer(1'b1, ccp_pkg::OFF_MASK, 32'h0F);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq_q}, 32'h1);
    xfer(1'b1, ccp_pkg::OFF_MASK, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq_q}, 32'h0);
    xfer(1'b1, ccp_pkg::OFF_STATUS, 32'h0F);
    rdc(ccp_pkg::OFF_STATUS, 32'h0);
    // Wrap from near the top; channels match again after it
    xfer(1'b1, ccp_pkg::OFF_COUNT, 32'hFFF0);
    xfer(1'b1, ccp_pkg::OFF_MASK, 32'h10);
    run(32'h80, 50);
    rdc(ccp_pkg::OFF_STATUS, 32'h1F);
    chk({31'h0, irq_q}, 32'h1);
    xfer(1'b1, ccp_pkg::OFF_STATUS, 32'h1F);
    $display("compare test done");
  endtask

  task automatic t_clear();
    xfer(1'b1, ccp_pkg::OFF_CTRL, 32'h80);
    xfer(1'b1, ccp_pkg::OFF_GRA, 32'h08);
    xfer(1'b1, ccp_pkg::OFF_COUNT, 32'h0);
    run(32'h80, 100);
    xfer(1'b0, ccp_pkg::OFF_COUNT, 32'h0);
    chk({31'h0, rd_q <= 32'h8}, 32'h1);
    rdc(ccp_pkg::OFF_STATUS, 32'h01);
    xfer(1'b1, ccp_pkg::OFF_STATUS, 32'h1F);
    $display("clear test done");
  endtask

  task automatic t_clocks();
    int dv;
    int ex;
    for (int k = 0; k < 7; k++) begin
      xfer(1'b1, ccp_pkg::OFF_CTRL, 32'(k << 4));
      xfer(1'b1, ccp_pkg::OFF_COUNT, 32'h0);
      run(32'h80, 512);
      xfer(1'b0, ccp_pkg::OFF_COUNT, 32'h0);
      dv = (k < 4) ? (1 << k) : (4 << (2 * (k - 4)));
      ex = 515 / dv;
      chk({31'h0, rd_q + 4 >= ex && rd_q <= ex + 4}, 32'h1);
    end
    xfer(1'b1, ccp_pkg::OFF_CTRL, 32'h70);
    xfer(1'b1, ccp_pkg::OFF_COUNT, 32'h0);
    xfer(1'b1, ccp_pkg::OFF_MODE, 32'h80);
    ccp_pins_model_i.ext_pulses(5, 3);
    ccp_pins_model_i.ext_pulses(3, 1);
    run(32'h80, 4);
    rdc(ccp_pkg::OFF_COUNT, 32'h8);
    $display("clock test done");
  endtask

  task automatic t_capture();
    xfer(1'b1, ccp_pkg::OFF_IOCTL, 32'hBA90);
    chk({28'h0, poe}, 32'h1);
    xfer(1'b1, ccp_pkg::OFF_COUNT, 32'h100);
    ccp_pins_model_i.set_pins(4'hE);
    repeat (4) @(posedge clk_sys);
    rdc(ccp_pkg::OFF_GRD, 32'h100);
    xfer(1'b1, ccp_pkg::OFF_COUNT, 32'h200);
    ccp_pins_model_i.set_pins(4'h0);
    repeat (4) @(posedge clk_sys);
    rdc(ccp_pkg::OFF_GRB, 32'h100);
    rdc(ccp_pkg::OFF_GRC, 32'h200);
    rdc(ccp_pkg::OFF_GRD, 32'h200);
    xfer(1'b1, ccp_pkg::OFF_IOCTL, 32'h0);
    $display("capture test done");
  endtask

  task automatic t_pwm();
    int hi [4];
    for (int j = 0; j < 4; j++) hi[j] = 0;
    // A starts high; having no PWM of its own it must stay there
    xfer(1'b1, ccp_pkg::OFF_CTRL, 32'h81);
    xfer(1'b1, ccp_pkg::OFF_GRA, 32'h3F);
    xfer(1'b1, ccp_pkg::OFF_GRB, 32'h0F);
    xfer(1'b1, ccp_pkg::OFF_GRC, 32'h1F);
    xfer(1'b1, ccp_pkg::OFF_GRD, 32'h2F);
    xfer(1'b1, ccp_pkg::OFF_COUNT, 32'h0);
    xfer(1'b1, ccp_pkg::OFF_MODE, 32'h87);
    repeat (64) @(posedge clk_sys);
    // Three whole periods of 64 counts
    repeat (192) begin
      @(posedge clk_sys);
      for (int j = 0; j < 4; j++) if (lvl[j] === 1'b1) hi[j]++;
    end
    xfer(1'b1, ccp_pkg::OFF_MODE, 32'h0);
    chk(32'(hi[0]), 32'hC0);
    chk({31'h0, hi[1] >= 45 && hi[1] <= 51}, 32'h1);
    chk({31'h0, hi[2] >= 93 && hi[2] <= 99}, 32'h1);
    chk({31'h0, hi[3] >= 141 && hi[3] <= 147}, 32'h1);
    // Buffer: matches reload A from C and B from D
    xfer(1'b1, ccp_pkg::OFF_GRA, 32'h20);
    xfer(1'b1, ccp_pkg::OFF_GRC, 32'h30);
    xfer(1'b1, ccp_pkg::OFF_COUNT, 32'h0);
    run(32'hB0, 60);
    rdc(ccp_pkg::OFF_GRA, 32'h30);
    rdc(ccp_pkg::OFF_GRB, 32'h2F);
    $display("pwm and buffer test done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence after 16 reset cycles
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_compare();
    t_clear();
    t_clocks();
    t_capture();
    t_pwm();
    end_of_test();
  end
endmodule // sixteen_bit_capture_compare_timer_bench
